// ### core/serial_port_pkg.sv
/*
  Shared constants and state types for the asynchronous serial port unit.
  Assumes a single clock domain; bit timing is supplied as a 16x tick.
*/
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Bit timing within one bit cell of sixteen ticks
  // ----------------------------------------------------------------
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam logic [3:0] TICK_SAMPLE = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_SCK_HIGH_BIT = 4'h8;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_LEN_8 = 4'h8;
  localparam logic [3:0] DATA_LEN_7 = 4'h7;
  localparam logic [3:0] STOP_LEN_1 = 4'h1;
  localparam logic [3:0] STOP_LEN_2 = 4'h2;
  localparam logic [3:0] START_LEN = 4'h1;
  localparam logic [3:0] ONE_COUNT = 4'h1;
  localparam logic [3:0] ZERO_COUNT = 4'h0;
  localparam logic [7:0] DATA_MASK_7 = 8'h7f;
  localparam logic [7:0] DATA_MASK_8 = 8'hff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_TX_COMPLETE = 1'b1;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_LINE = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_COUNT = 4'h0;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    TX_IDLE  = 7'h01,
    TX_MARK  = 7'h02,
    TX_WAIT  = 7'h04,
    TX_START = 7'h08,
    TX_DATA  = 7'h10,
    TX_EXTRA = 7'h20,
    TX_STOP  = 7'h40
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_EXTRA = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_t;

endpackage

// ### core/bit_sync.sv
/*
  Two-stage synchroniser for one asynchronous level.
  Assumes the input may change at any time relative to i_mclk.
*/
`timescale 1ns/1ps
module bit_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_r;

  // Reset to mark so an idle line is not seen as a start bit
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= serial_port_pkg::RST_LINE;
      o_sync <= serial_port_pkg::RST_LINE;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ### core/serial_port_unit.sv
/*
  Asynchronous serial port: double-buffered transmitter and receiver,
  parity and multiprocessor formats, status flags and request levels.
  Assumes software drives the control levels and one-cycle strobes on the
  same clock, and that a baud generator supplies a 16x tick pulse.
*/
`timescale 1ns/1ps
module serial_port_unit (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_baud_tick16,
  input wire logic i_sck_in,
  input wire logic i_rxd,
  input wire logic i_clock_src_ext,
  input wire logic i_clock_pin_out,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic i_char_length_select,
  input wire logic i_parity_on,
  input wire logic i_parity_odd_select,
  input wire logic i_multiproc_format_on,
  input wire logic i_two_stop_bits,
  input wire logic i_tx_empty_int_enable,
  input wire logic i_tx_end_int_enable,
  input wire logic i_rx_int_enable,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_data_wr,
  input wire logic i_tx_mpb,
  input wire logic i_tx_buffer_empty_clr,
  input wire logic i_rx_buffer_full_clr,
  input wire logic i_overrun_clr,
  input wire logic i_framing_error_clr,
  input wire logic i_parity_error_clr,
  input wire logic i_mp_wait_set,
  input wire logic i_pin_direction_bit,
  input wire logic i_pin_output_level,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_sck_out,
  output logic o_sck_oe,
  output logic o_tx_buffer_empty,
  output logic o_tx_complete,
  output logic o_rx_buffer_full,
  output logic o_overrun_flag,
  output logic o_framing_error_flag,
  output logic o_parity_error_flag,
  output logic [7:0] o_rx_data,
  output logic o_rx_mpb,
  output logic o_mp_waiting,
  output logic o_tx_empty_irq,
  output logic o_tx_end_irq,
  output logic o_rx_full_irq,
  output logic o_rx_error_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers and tick selection
  // ----------------------------------------------------------------
  logic rxd_s;
  logic sck_s;
  logic rxd_q_r;
  logic sck_q_r;

  bit_sync u_rxd_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_rxd),
    .o_sync(rxd_s)
  );

  bit_sync u_sck_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_sck_in),
    .o_sync(sck_s)
  );

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rxd_q_r <= serial_port_pkg::RST_LINE;
      // Same level as the synchroniser's reset, so no false tick follows reset
      sck_q_r <= serial_port_pkg::RST_LINE;
    end else begin
      rxd_q_r <= rxd_s;
      sck_q_r <= sck_s;
    end
  end

  // Every rising edge of a 16x pin clock is one tick; a stopped clock stalls both sides
  wire ext_rise = sck_s & ~sck_q_r;
  wire tick16 = i_clock_src_ext ? ext_rise : i_baud_tick16;
  wire rx_fall = rxd_q_r & ~rxd_s;

  // ----------------------------------------------------------------
  // Frame format decode
  // ----------------------------------------------------------------
  wire par_en = i_parity_on & ~i_multiproc_format_on;
  wire extra_en = par_en | i_multiproc_format_on;
  wire [3:0] data_len = i_char_length_select ? serial_port_pkg::DATA_LEN_7 :
                        serial_port_pkg::DATA_LEN_8;
  wire [3:0] stop_len = i_two_stop_bits ? serial_port_pkg::STOP_LEN_2 :
                        serial_port_pkg::STOP_LEN_1;
  wire [3:0] extra_len = {3'h0, extra_en};
  wire [3:0] frame_len = serial_port_pkg::START_LEN + data_len + extra_len + stop_len;
  wire [7:0] data_mask = i_char_length_select ? serial_port_pkg::DATA_MASK_7 :
                         serial_port_pkg::DATA_MASK_8;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  serial_port_pkg::tx_state_t tx_state_r;
  serial_port_pkg::tx_state_t tx_state_nxt;
  logic [3:0] tx_ph_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic [7:0] tx_holding_reg_r;
  logic tx_holding_mpb_r;
  logic [7:0] tx_shift_reg_r;
  logic [7:0] tx_shift_nxt;
  logic tx_extra_r;
  logic tx_buffer_empty_r;
  logic tx_complete_r;
  logic tx_load;
  logic tx_end_set;
  logic tx_line;

  wire tx_bit_end = tick16 & (tx_ph_r == serial_port_pkg::TICK_LAST);
  wire [3:0] tx_ph_nxt = tick16 ? tx_ph_r + 4'h1 : tx_ph_r;
  wire [7:0] tx_load_data = tx_holding_reg_r & data_mask;
  wire tx_load_extra = i_multiproc_format_on ? tx_holding_mpb_r :
                       (^tx_load_data) ^ i_parity_odd_select;
  wire tx_last = (tx_cnt_r == serial_port_pkg::ONE_COUNT);

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_shift_nxt = tx_shift_reg_r;
    tx_load = 1'b0;
    tx_end_set = 1'b0;
    tx_line = 1'b1;
    unique case (tx_state_r)
      serial_port_pkg::TX_IDLE: begin
        if (i_tx_enable) begin
          // One spare bit covers the partial cell at enable time
          tx_state_nxt = serial_port_pkg::TX_MARK;
          tx_cnt_nxt = frame_len + serial_port_pkg::ONE_COUNT;
        end
      end
      serial_port_pkg::TX_MARK: begin
        if (tx_bit_end) begin
          tx_cnt_nxt = tx_cnt_r - serial_port_pkg::ONE_COUNT;
          if (tx_last) begin
            tx_state_nxt = serial_port_pkg::TX_WAIT;
          end
        end
      end
      serial_port_pkg::TX_WAIT: begin
        if (tx_bit_end && !tx_buffer_empty_r) begin
          tx_load = 1'b1;
          tx_state_nxt = serial_port_pkg::TX_START;
        end
      end
      serial_port_pkg::TX_START: begin
        tx_line = 1'b0;
        if (tx_bit_end) begin
          tx_state_nxt = serial_port_pkg::TX_DATA;
          tx_cnt_nxt = data_len;
        end
      end
      serial_port_pkg::TX_DATA: begin
        tx_line = tx_shift_reg_r[0];
        if (tx_bit_end) begin
          tx_shift_nxt = {1'b0, tx_shift_reg_r[7:1]};
          tx_cnt_nxt = tx_cnt_r - serial_port_pkg::ONE_COUNT;
          if (tx_last) begin
            tx_state_nxt = extra_en ? serial_port_pkg::TX_EXTRA : serial_port_pkg::TX_STOP;
            tx_cnt_nxt = stop_len;
          end
        end
      end
      serial_port_pkg::TX_EXTRA: begin
        tx_line = tx_extra_r;
        if (tx_bit_end) begin
          tx_state_nxt = serial_port_pkg::TX_STOP;
        end
      end
      serial_port_pkg::TX_STOP: begin
        if (tx_bit_end) begin
          tx_cnt_nxt = tx_cnt_r - serial_port_pkg::ONE_COUNT;
          if (tx_last && !tx_buffer_empty_r) begin
            tx_load = 1'b1;
            tx_state_nxt = serial_port_pkg::TX_START;
          end else if (tx_last) begin
            tx_end_set = 1'b1;
            tx_state_nxt = serial_port_pkg::TX_WAIT;
          end
        end
      end
    endcase
    if (tx_load) begin
      tx_shift_nxt = tx_load_data;
    end
    if (!i_tx_enable) begin
      tx_state_nxt = serial_port_pkg::TX_IDLE;
      tx_shift_nxt = serial_port_pkg::RST_BYTE;
      tx_load = 1'b0;
      tx_end_set = 1'b0;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  wire tx_empty_nxt = ~i_tx_enable | tx_load |
                      (tx_buffer_empty_r & ~i_tx_buffer_empty_clr);
  wire tx_complete_nxt = tx_end_set | (tx_complete_r & ~i_tx_buffer_empty_clr);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_state_r <= serial_port_pkg::TX_IDLE;
      tx_ph_r <= serial_port_pkg::RST_COUNT;
      tx_cnt_r <= serial_port_pkg::RST_COUNT;
      tx_shift_reg_r <= serial_port_pkg::RST_BYTE;
      tx_extra_r <= serial_port_pkg::RST_FLAG;
      tx_buffer_empty_r <= serial_port_pkg::RST_TX_EMPTY;
      tx_complete_r <= serial_port_pkg::RST_TX_COMPLETE;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_ph_r <= tx_ph_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_shift_reg_r <= tx_shift_nxt;
      tx_extra_r <= tx_load ? tx_load_extra : tx_extra_r;
      tx_buffer_empty_r <= tx_empty_nxt;
      tx_complete_r <= tx_complete_nxt;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_holding_reg_r <= serial_port_pkg::RST_BYTE;
      tx_holding_mpb_r <= serial_port_pkg::RST_FLAG;
    end else if (i_tx_data_wr) begin
      tx_holding_reg_r <= i_tx_data;
      tx_holding_mpb_r <= i_tx_mpb;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // With transmit off the pin falls back to a plain port bit, which is how a break is held
  wire txd_nxt = i_tx_enable ? tx_line : i_pin_output_level;
  wire txd_oe_nxt = i_tx_enable | i_pin_direction_bit;
  wire sck_oe_nxt = ~i_clock_src_ext & i_clock_pin_out;
  // Phase 8 of 16 is mid-cell, so the rising edge lands in the bit centre
  wire sck_nxt = sck_oe_nxt & (tx_ph_nxt >= serial_port_pkg::TICK_SCK_HIGH_BIT);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_txd <= serial_port_pkg::RST_LINE;
      o_txd_oe <= serial_port_pkg::RST_FLAG;
      o_sck_out <= serial_port_pkg::RST_FLAG;
      o_sck_oe <= serial_port_pkg::RST_FLAG;
    end else begin
      o_txd <= txd_nxt;
      o_txd_oe <= txd_oe_nxt;
      o_sck_out <= sck_nxt;
      o_sck_oe <= sck_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  serial_port_pkg::rx_state_t rx_state_r;
  serial_port_pkg::rx_state_t rx_state_nxt;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_ph_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic [7:0] rx_shift_reg_r;
  logic rx_extra_r;
  logic rx_finish;
  logic rx_store;
  logic rx_store_extra;

  wire rx_err_any = o_overrun_flag | o_framing_error_flag | o_parity_error_flag;
  wire rx_sample = tick16 & (rx_ph_r == serial_port_pkg::TICK_SAMPLE);

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_ph_nxt = tick16 ? rx_ph_r + 4'h1 : rx_ph_r;
    rx_finish = 1'b0;
    rx_store = 1'b0;
    rx_store_extra = 1'b0;
    unique case (rx_state_r)
      serial_port_pkg::RX_IDLE: begin
        // Errors hold the receiver here until software clears them
        if (i_rx_enable && !rx_err_any && rx_fall) begin
          rx_state_nxt = serial_port_pkg::RX_START;
          rx_ph_nxt = serial_port_pkg::RST_COUNT;
        end
      end
      serial_port_pkg::RX_START: begin
        if (rx_sample) begin
          // A glitch that is high again at mid-cell is not a start bit
          rx_state_nxt = rxd_s ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
          rx_cnt_nxt = serial_port_pkg::ZERO_COUNT;
        end
      end
      serial_port_pkg::RX_DATA: begin
        if (rx_sample) begin
          rx_store = 1'b1;
          rx_cnt_nxt = rx_cnt_r + serial_port_pkg::ONE_COUNT;
          if (rx_cnt_r == data_len - serial_port_pkg::ONE_COUNT) begin
            rx_state_nxt = extra_en ? serial_port_pkg::RX_EXTRA : serial_port_pkg::RX_STOP;
          end
        end
      end
      serial_port_pkg::RX_EXTRA: begin
        if (rx_sample) begin
          rx_store_extra = 1'b1;
          rx_state_nxt = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: begin
        if (rx_sample) begin
          // Only the first stop bit is looked at; a second one idles high anyway
          rx_finish = 1'b1;
          rx_state_nxt = serial_port_pkg::RX_IDLE;
        end
      end
    endcase
    if (!i_rx_enable) begin
      rx_state_nxt = serial_port_pkg::RX_IDLE;
      rx_finish = 1'b0;
      rx_store = 1'b0;
      rx_store_extra = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_state_r <= serial_port_pkg::RX_IDLE;
      rx_ph_r <= serial_port_pkg::RST_COUNT;
      rx_cnt_r <= serial_port_pkg::RST_COUNT;
      rx_shift_reg_r <= serial_port_pkg::RST_BYTE;
      rx_extra_r <= serial_port_pkg::RST_FLAG;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_ph_r <= rx_ph_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      if (rx_state_nxt == serial_port_pkg::RX_START) begin
        rx_shift_reg_r <= serial_port_pkg::RST_BYTE;
        rx_extra_r <= serial_port_pkg::RST_FLAG;
      end else begin
        if (rx_store) begin
          rx_shift_reg_r[rx_cnt_r[2:0]] <= rxd_s;
        end
        if (rx_store_extra) begin
          rx_extra_r <= rxd_s;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive checks and flags
  // ----------------------------------------------------------------
  wire mp_skip = i_multiproc_format_on & o_mp_waiting & ~rx_extra_r;
  wire rx_accept = rx_finish & ~mp_skip;
  wire rx_overrun = rx_accept & o_rx_buffer_full;
  wire rx_take = rx_accept & ~o_rx_buffer_full;
  wire rx_frame_bad = rx_take & ~rxd_s;
  wire rx_par_bad = rx_take & par_en &
                    (((^rx_shift_reg_r) ^ rx_extra_r) != i_parity_odd_select);
  wire rx_good = rx_take & ~rx_frame_bad & ~rx_par_bad;
  wire mp_id_seen = rx_take & i_multiproc_format_on & rx_extra_r;

  // Set wins over clear; receive disable touches none of these
  wire rx_buffer_full_nxt = rx_good | (o_rx_buffer_full & ~i_rx_buffer_full_clr);
  wire overrun_flag_nxt = rx_overrun | (o_overrun_flag & ~i_overrun_clr);
  wire fer_nxt = rx_frame_bad | (o_framing_error_flag & ~i_framing_error_clr);
  wire per_nxt = rx_par_bad | (o_parity_error_flag & ~i_parity_error_clr);
  // A software arm in the same cycle as an id wins, so a mismatch can be re-armed at once
  wire mp_wait_nxt = i_mp_wait_set | (o_mp_waiting & ~mp_id_seen);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_buffer_full <= serial_port_pkg::RST_FLAG;
      o_overrun_flag <= serial_port_pkg::RST_FLAG;
      o_framing_error_flag <= serial_port_pkg::RST_FLAG;
      o_parity_error_flag <= serial_port_pkg::RST_FLAG;
      o_mp_waiting <= serial_port_pkg::RST_FLAG;
      o_rx_data <= serial_port_pkg::RST_BYTE;
      o_rx_mpb <= serial_port_pkg::RST_FLAG;
    end else begin
      o_rx_buffer_full <= rx_buffer_full_nxt;
      o_overrun_flag <= overrun_flag_nxt;
      o_framing_error_flag <= fer_nxt;
      o_parity_error_flag <= per_nxt;
      o_mp_waiting <= mp_wait_nxt;
      // Characters with framing or parity errors are still visible, but full is not raised
      if (rx_take) begin
        o_rx_data <= rx_shift_reg_r;
        o_rx_mpb <= rx_extra_r & i_multiproc_format_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and request outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_buffer_empty <= serial_port_pkg::RST_TX_EMPTY;
      o_tx_complete <= serial_port_pkg::RST_TX_COMPLETE;
      o_tx_empty_irq <= serial_port_pkg::RST_FLAG;
      o_tx_end_irq <= serial_port_pkg::RST_FLAG;
      o_rx_full_irq <= serial_port_pkg::RST_FLAG;
      o_rx_error_irq <= serial_port_pkg::RST_FLAG;
    end else begin
      o_tx_buffer_empty <= tx_empty_nxt;
      o_tx_complete <= tx_complete_nxt;
      o_tx_empty_irq <= tx_empty_nxt & i_tx_empty_int_enable;
      o_tx_end_irq <= tx_complete_nxt & i_tx_end_int_enable;
      o_rx_full_irq <= rx_buffer_full_nxt & i_rx_int_enable;
      o_rx_error_irq <= (overrun_flag_nxt | fer_nxt | per_nxt) & i_rx_int_enable;
    end
  end

endmodule

// ### testbench/serial_port_unit_asserts.sv
/* Concurrent checks on the serial port unit ports.
   Assumes one clock i_mclk and an asynchronous active-high i_rst. */
`timescale 1ns/1ps
module serial_port_unit_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic i_tx_empty_int_enable,
  input wire logic i_tx_end_int_enable,
  input wire logic i_rx_int_enable,
  input wire logic i_rx_buffer_full_clr,
  input wire logic i_clock_src_ext,
  input wire logic i_clock_pin_out,
  input wire logic o_txd,
  input wire logic o_sck_out,
  input wire logic o_tx_buffer_empty,
  input wire logic o_tx_complete,
  input wire logic o_rx_buffer_full,
  input wire logic o_overrun_flag,
  input wire logic o_framing_error_flag,
  input wire logic o_parity_error_flag,
  input wire logic [7:0] o_rx_data,
  input wire logic o_tx_empty_irq,
  input wire logic o_tx_end_irq,
  input wire logic o_rx_full_irq,
  input wire logic o_rx_error_irq
);
  logic rx_err;
  assign rx_err = o_overrun_flag | o_framing_error_flag | o_parity_error_flag;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_empty_irq_map: assert property (!$past(i_rst) && $stable(i_tx_empty_int_enable)
    |-> o_tx_empty_irq == (o_tx_buffer_empty && i_tx_empty_int_enable))
    else $error("empty request does not follow its flag");
  a_done_irq_map: assert property (!$past(i_rst) && $stable(i_tx_end_int_enable)
    |-> o_tx_end_irq == (o_tx_complete && i_tx_end_int_enable))
    else $error("end request does not follow its flag");
  a_full_irq_map: assert property ($stable(i_rx_int_enable)
    |-> o_rx_full_irq == (o_rx_buffer_full && i_rx_int_enable))
    else $error("full request does not follow its flag");
  a_err_irq_map: assert property ($stable(i_rx_int_enable)
    |-> o_rx_error_irq == (rx_err && i_rx_int_enable))
    else $error("error request does not follow the flags");
  a_tx_off_empty: assert property ($fell(i_tx_enable) |=> o_tx_buffer_empty)
    else $error("empty flag not forced on transmit disable");
  a_rx_off_hold: assert property (!i_rx_enable && !$past(i_rx_enable)
    && !i_rx_buffer_full_clr |=> $stable({o_rx_data, o_rx_buffer_full}))
    else $error("receive state changed while disabled");
  a_err_blocks: assert property ($past(rx_err) |-> !$rose(o_rx_buffer_full))
    else $error("character accepted while an error flag stands");
  a_sck_mid_bit: assert property (i_tx_enable && $past(i_tx_enable, 2) && !i_clock_src_ext
    && i_clock_pin_out && $changed(o_txd) |-> !o_sck_out)
    else $error("bit clock high at a bit boundary");
endmodule
bind serial_port_unit serial_port_unit_asserts i_chk (.*);

// ### testbench/serial_station.sv
/* Remote serial station: sends frames to the device receive line and
   decodes 8-bit frames from its transmit line. Assumes bl clocks a bit. */
`timescale 1ns/1ps
module serial_station (
  input wire logic i_mclk,
  input wire logic i_line,
  output logic o_line,
  output logic [7:0] o_got,
  output int o_count
);
  logic [7:0] sh;
  // Clocks per bit; doubled while the device runs from the half-rate pin clock
  int bl = 16;
  initial begin
    o_line = 1'b1;
    o_count = 0;
    o_got = 8'h00;
  end
  task automatic put(input logic b);
    @(posedge i_mclk);
    o_line <= b;
    repeat (bl - 1) @(posedge i_mclk);
  endtask
  // Stop level is a parameter so a broken frame can be commanded
  task automatic send(input logic [7:0] d, input int n, input logic ex_on, ex, stp);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (ex_on) put(ex);
    put(stp);
    put(1'b1);
  endtask
  always begin
    @(negedge i_line);
    repeat (bl / 2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bl) @(posedge i_mclk);
      sh[i] = i_line;
    end
    o_got = sh;
    o_count = o_count + 1;
    repeat (bl) @(posedge i_mclk);
  end
endmodule

// ### testbench/serial_port_unit_tb.sv
/* Self-checking bench for serial_port_unit with a remote station model.
   Assumes the 16x tick is high every clock; the pin clock runs at half that rate. */
`timescale 1ns/1ps
module serial_port_unit_tb;
  logic i_mclk, i_rst, i_baud_tick16, i_sck_in, i_rxd, i_clock_src_ext, i_clock_pin_out;
  logic i_tx_enable, i_rx_enable, i_char_length_select, i_parity_on, i_parity_odd_select;
  logic i_multiproc_format_on, i_two_stop_bits, i_tx_empty_int_enable, i_tx_end_int_enable;
  logic i_rx_int_enable, i_tx_data_wr, i_tx_mpb, i_tx_buffer_empty_clr, i_rx_buffer_full_clr;
  logic i_overrun_clr, i_framing_error_clr, i_parity_error_clr, i_mp_wait_set;
  logic i_pin_direction_bit, i_pin_output_level, o_txd, o_txd_oe, o_sck_out, o_sck_oe;
  logic o_tx_buffer_empty, o_tx_complete, o_rx_buffer_full, o_overrun_flag, o_rx_mpb;
  logic o_framing_error_flag, o_parity_error_flag, o_mp_waiting, o_tx_empty_irq;
  logic o_tx_end_irq, o_rx_full_irq, o_rx_error_irq;
  logic [7:0] i_tx_data, o_rx_data, got;
  int seen, miscompares = 0, n_tests = 0, cycles = 0;
  serial_port_unit i_dut (.*);
  serial_station i_stn (.i_mclk(i_mclk), .i_line(o_txd), .o_line(i_rxd), .o_got(got),
    .o_count(seen));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // The pin clock never stops, not even while the port is reconfigured
  always #25 i_sck_in = ~i_sck_in;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] msk(input logic l7);
    return l7 ? serial_port_pkg::DATA_MASK_7 : serial_port_pkg::DATA_MASK_8;
  endfunction
  function automatic logic par(input logic [7:0] d, input logic l7, odd);
    return ^(d & msk(l7)) ^ odd;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_mclk);
    s = 1'b1;
    @(negedge i_mclk);
    s = 1'b0;
  endtask
  // Format only changes with the receiver off
  task automatic cfg(input logic l7, po, odd, mp, ext);
    @(negedge i_mclk);
    i_rx_enable = 1'b0;
    {i_char_length_select, i_parity_on, i_parity_odd_select} = {l7, po, odd};
    i_multiproc_format_on = mp;
    i_two_stop_bits = 1'($urandom);
    i_clock_src_ext = ext;
    i_stn.bl = ext ? 32 : 16;
    @(negedge i_mclk);
    i_rx_enable = 1'b1;
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic ex, stp);
    i_stn.send(d, i_char_length_select ? 7 : 8, i_parity_on | i_multiproc_format_on, ex, stp);
    repeat (4) @(negedge i_mclk);
  endtask
  task automatic tx_char(input logic [7:0] d);
    @(negedge i_mclk);
    i_tx_data = d;
    i_tx_mpb = 1'($urandom);
    pulse(i_tx_data_wr);
    pulse(i_tx_buffer_empty_clr);
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    {i_rst, i_baud_tick16, i_pin_output_level} = 3'b111;
    {i_sck_in, i_clock_src_ext, i_clock_pin_out, i_tx_enable, i_rx_enable} = '0;
    {i_char_length_select, i_parity_on, i_parity_odd_select, i_multiproc_format_on} = '0;
    {i_two_stop_bits, i_tx_empty_int_enable, i_tx_end_int_enable, i_rx_int_enable} = '0;
    {i_tx_data_wr, i_tx_mpb, i_tx_buffer_empty_clr, i_rx_buffer_full_clr} = '0;
    {i_overrun_clr, i_framing_error_clr, i_parity_error_clr, i_mp_wait_set} = '0;
    {i_pin_direction_bit, i_tx_data} = '0;
    void'($urandom(17542));
    repeat (10) @(negedge i_mclk);
    i_rst = 1'b0;
    {i_rx_int_enable, i_clock_pin_out} = 2'b11;
    for (int k = 0; k < 4; k++) begin
      cfg(k[1], 1'b1, k[0], 1'b0, 1'b0);
      d = 8'($urandom);
      rx_frame(d, par(d, k[1], k[0]), 1'b1);
      chk(o_rx_buffer_full, 1);
      chk(o_rx_full_irq, 1);
      chk(o_rx_data, d & msk(k[1]));
      pulse(i_rx_buffer_full_clr);
    end
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_frame(d, 1'b0, 1'b1);
    rx_frame(~d, 1'b0, 1'b1);
    chk(o_overrun_flag, 1);
    chk(o_rx_error_irq, 1);
    chk(o_rx_data, d);
    @(negedge i_mclk) i_rx_enable = 1'b0;
    repeat (40) @(negedge i_mclk);
    chk({o_rx_buffer_full, o_overrun_flag}, 8'h03);
    pulse(i_rx_buffer_full_clr);
    pulse(i_overrun_clr);
    i_rx_enable = 1'b1;
    rx_frame(d, 1'b0, 1'b0);
    chk(o_framing_error_flag, 1);
    rx_frame(~d, 1'b0, 1'b1);
    chk(o_rx_buffer_full, 0);
    chk(o_rx_data, d);
    pulse(i_framing_error_clr);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rx_frame(d, ~par(d, 1'b0, 1'b0), 1'b1);
    chk(o_parity_error_flag, 1);
    pulse(i_parity_error_clr);
    cfg(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    pulse(i_mp_wait_set);
    rx_frame(d, 1'b0, 1'b1);
    chk({o_rx_buffer_full, o_mp_waiting}, 8'h01);
    rx_frame(~d, 1'b1, 1'b1);
    chk({o_rx_buffer_full, o_rx_mpb, o_mp_waiting, o_parity_error_flag}, 8'h0c);
    chk(o_rx_data, ~d);
    pulse(i_rx_buffer_full_clr);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rx_frame(d, 1'b0, 1'b1);
    chk({o_rx_buffer_full, o_sck_oe}, 8'h02);
    chk(o_rx_data, d);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    {i_tx_empty_int_enable, i_tx_end_int_enable, i_tx_enable} = 3'b111;
    tx_char(d);
    repeat (150) @(negedge i_mclk);
    chk(seen[7:0], 8'h00);
    for (int i = 0; i < 300 && o_tx_buffer_empty !== 1'b1; i++) @(negedge i_mclk);
    chk({o_tx_buffer_empty, o_tx_empty_irq}, 8'h03);
    tx_char(~d);
    for (int i = 0; i < 400 && seen != 1; i++) @(negedge i_mclk);
    chk(got, d);
    for (int i = 0; i < 200 && seen != 2; i++) @(negedge i_mclk);
    chk(got, ~d);
    for (int i = 0; i < 100 && o_tx_complete !== 1'b1; i++) @(negedge i_mclk);
    chk({o_tx_complete, o_tx_end_irq}, 8'h03);
    {i_pin_direction_bit, i_pin_output_level} = 2'b10;
    tx_char(d);
    @(negedge i_mclk) i_tx_enable = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk(o_tx_buffer_empty, 1);
    chk({o_txd, o_txd_oe}, 8'h01);
    chk(o_sck_oe, 1);
    report_and_stop();
  end
endmodule
